// ===== cod_pkg.sv
// Constants, types and reset state for the opcode decoder.
package cod_pkg;

    // Three-bit register field codes.
    localparam logic [2:0] REG_B   = 3'h0;
    localparam logic [2:0] REG_C   = 3'h1;
    localparam logic [2:0] REG_D   = 3'h2;
    localparam logic [2:0] REG_E   = 3'h3;
    localparam logic [2:0] REG_H   = 3'h4;
    localparam logic [2:0] REG_L   = 3'h5;
    localparam logic [2:0] REG_MEM = 3'h6;
    localparam logic [2:0] REG_A   = 3'h7;

    // Two-bit pair field codes; code 3 is the stack pointer or acc/flags.
    localparam logic [1:0] PAIR_BC   = 2'h0;
    localparam logic [1:0] PAIR_DE   = 2'h1;
    localparam logic [1:0] PAIR_HL   = 2'h2;
    localparam logic [1:0] PAIR_HIGH = 2'h3;

    // Condition codes.
    localparam logic [2:0] COND_NOT_ZERO    = 3'h0;
    localparam logic [2:0] COND_ZERO        = 3'h1;
    localparam logic [2:0] COND_NO_CARRY    = 3'h2;
    localparam logic [2:0] COND_CARRY       = 3'h3;
    localparam logic [2:0] COND_PARITY_ODD  = 3'h4;
    localparam logic [2:0] COND_PARITY_EVEN = 3'h5;
    localparam logic [2:0] COND_POSITIVE    = 3'h6;
    localparam logic [2:0] COND_MINUS       = 3'h7;

    // Fixed opcodes.
    localparam logic [7:0] OPC_HALT_SLOT      = 8'h76;
    localparam logic [7:0] OPC_STORE_IMM_MEM  = 8'h36;
    localparam logic [7:0] OPC_STORE_PTR      = 8'h22;
    localparam logic [7:0] OPC_LOAD_PTR       = 8'h2A;
    localparam logic [7:0] OPC_SWAP_PAIRS     = 8'hEB;
    localparam logic [7:0] OPC_SWAP_STACK_TOP = 8'hE3;
    localparam logic [7:0] OPC_SP_INCREMENT   = 8'h33;
    localparam logic [7:0] OPC_SP_DECREMENT   = 8'h3B;
    localparam logic [7:0] OPC_BRANCH_ALWAYS  = 8'hC3;
    localparam logic [7:0] OPC_BRANCH_PTR     = 8'hE9;
    localparam logic [7:0] OPC_SUBCALL        = 8'hCD;

    // Stack pointer step, two's complement.
    localparam logic [2:0] SP_STEP_NONE = 3'h0;
    localparam logic [2:0] SP_STEP_INC1 = 3'h1;
    localparam logic [2:0] SP_STEP_INC2 = 3'h2;
    localparam logic [2:0] SP_STEP_DEC1 = 3'h7;
    localparam logic [2:0] SP_STEP_DEC2 = 3'h6;

    // Operand byte counts.
    localparam logic [1:0] OPND_NONE = 2'h0;
    localparam logic [1:0] OPND_BYTE = 2'h1;
    localparam logic [1:0] OPND_WORD = 2'h2;

    typedef enum logic [4:0] {
        OP_NONE,
        OP_COPY_REGISTER,
        OP_LOAD_REG_FROM_MEM,
        OP_LOAD_IMMEDIATE_BYTE,
        OP_STORE_IMMEDIATE_MEM,
        OP_LOAD_IMMEDIATE_PAIR,
        OP_STORE_ACC_INDIRECT,
        OP_LOAD_ACC_INDIRECT,
        OP_STORE_POINTER_DIRECT,
        OP_LOAD_POINTER_DIRECT,
        OP_SWAP_POINTER_PAIRS,
        OP_PUSH_PAIR,
        OP_POP_PAIR,
        OP_SWAP_STACK_TOP_POINTER,
        OP_PAIR_INCREMENT,
        OP_PAIR_DECREMENT,
        OP_BRANCH_ALWAYS,
        OP_BRANCH_COND,
        OP_BRANCH_TO_POINTER,
        OP_SUBCALL,
        OP_SUBCALL_COND
    } cod_op_type;

    typedef enum logic [1:0] {
        PH_OPCODE,
        PH_LOW,
        PH_HIGH
    } cod_phase_type;

    typedef struct packed {
        cod_phase_type phase;
        cod_op_type    op;
        logic [2:0]    dst;
        logic [2:0]    src;
        logic [1:0]    pair;
        logic          pair_sp;
        logic          pair_af;
        logic [1:0]    opnd_count;
        logic [15:0]   opnd;
        logic [2:0]    cond;
        logic          cond_used;
        logic          taken;
        logic [2:0]    sp_step;
        logic          issue;
        logic          unsupported;
    } cod_state_type;

    localparam cod_state_type COD_STATE_RESET = '{
        phase:       PH_OPCODE,
        op:          OP_NONE,
        dst:         3'h0,
        src:         3'h0,
        pair:        2'h0,
        pair_sp:     1'b0,
        pair_af:     1'b0,
        opnd_count:  2'h0,
        opnd:        16'h0000,
        cond:        3'h0,
        cond_used:   1'b0,
        taken:       1'b0,
        sp_step:     3'h0,
        issue:       1'b0,
        unsupported: 1'b0
    };

endpackage : cod_pkg

// ===== cod_cond_if.sv
// Interface between the decoder and its condition evaluator.
`timescale 1ns/100ps
interface cod_cond_if;
    logic [2:0] cond_code;
    logic       flag_zero;
    logic       flag_carry;
    logic       flag_parity;
    logic       flag_sign;
    logic       holds;

    modport requester (
        output cond_code,
        output flag_zero,
        output flag_carry,
        output flag_parity,
        output flag_sign,
        input  holds
    );

    modport evaluator (
        input  cond_code,
        input  flag_zero,
        input  flag_carry,
        input  flag_parity,
        input  flag_sign,
        output holds
    );
endinterface : cod_cond_if

// ===== cod_cond_eval.sv
// Condition evaluator shared by conditional branches and calls.
`timescale 1ns/100ps
module cod_cond_eval
    import cod_pkg::*;
(
    cod_cond_if.evaluator cond_port
);

    // The parity flag is set for even parity.
    always_comb
    begin
        unique case (cond_port.cond_code)
            COND_NOT_ZERO:    cond_port.holds = ~cond_port.flag_zero;
            COND_ZERO:        cond_port.holds = cond_port.flag_zero;
            COND_NO_CARRY:    cond_port.holds = ~cond_port.flag_carry;
            COND_CARRY:       cond_port.holds = cond_port.flag_carry;
            COND_PARITY_ODD:  cond_port.holds = ~cond_port.flag_parity;
            COND_PARITY_EVEN: cond_port.holds = cond_port.flag_parity;
            COND_POSITIVE:    cond_port.holds = ~cond_port.flag_sign;
            COND_MINUS:       cond_port.holds = cond_port.flag_sign;
        endcase
    end

endmodule : cod_cond_eval

// ===== cod_opcode_decoder.sv
// Opcode decoder with operand byte collection for the 8-bit processor.
`timescale 1ns/100ps
module cod_opcode_decoder
    import cod_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        reset_n_in,
    input  wire logic        byte_valid_in,
    input  wire logic [7:0]  byte_in,
    input  wire logic        flag_zero_in,
    input  wire logic        flag_carry_in,
    input  wire logic        flag_parity_in,
    input  wire logic        flag_sign_in,
    output logic             dec_valid_out,
    output cod_op_type       op_out,
    output logic [2:0]       dst_sel_out,
    output logic [2:0]       src_sel_out,
    output logic             dst_is_mem_out,
    output logic             src_is_mem_out,
    output logic [1:0]       pair_sel_out,
    output logic             pair_is_sp_out,
    output logic             pair_is_acc_flags_out,
    output logic [15:0]      operand_out,
    output logic             cond_taken_out,
    output logic [2:0]       sp_step_out,
    output logic             unsupported_out,
    output logic             busy_out
);

    cod_state_type s_q;
    cod_state_type s_d;
    logic [7:0]    opc;

    cod_cond_if cond_bus ();

    cod_cond_eval u_cond_eval (
        .cond_port (cond_bus.evaluator)
    );

    // Flags are sampled in the cycle that the high operand byte arrives, one cycle before the instruction issues.
    assign cond_bus.flag_zero   = flag_zero_in;
    assign cond_bus.flag_carry  = flag_carry_in;
    assign cond_bus.flag_parity = flag_parity_in;
    assign cond_bus.flag_sign   = flag_sign_in;
    assign opc                  = byte_in;

    // In the opcode phase the code comes from the incoming byte, though no
    // opcode without an operand uses it; otherwise from the captured field.
    assign cond_bus.cond_code = (s_q.phase == PH_OPCODE) ? opc[5:3]
                                                         : s_q.cond;

    always_comb
    begin
        s_d             = s_q;
        s_d.issue       = 1'b0;
        s_d.unsupported = 1'b0;
        unique case (s_q.phase)
            PH_OPCODE:
            begin
                if (byte_valid_in)
                begin
                    s_d.op         = OP_NONE;
                    s_d.dst        = opc[5:3];
                    s_d.src        = opc[2:0];
                    s_d.pair       = opc[5:4];
                    s_d.pair_sp    = 1'b0;
                    s_d.pair_af    = 1'b0;
                    s_d.opnd_count = OPND_NONE;
                    s_d.opnd       = 16'h0000;
                    s_d.cond       = opc[5:3];
                    s_d.cond_used  = 1'b0;
                    s_d.sp_step    = SP_STEP_NONE;
                    // The halt code sits inside the copy pattern, so the
                    // order of these items matters.
                    priority casez (opc)
                        OPC_HALT_SLOT:
                            s_d.unsupported = 1'b1;
                        8'b01???110:
                            s_d.op = OP_LOAD_REG_FROM_MEM;
                        8'b01??????:
                            s_d.op = OP_COPY_REGISTER;
                        OPC_STORE_IMM_MEM:
                        begin
                            s_d.op         = OP_STORE_IMMEDIATE_MEM;
                            s_d.opnd_count = OPND_BYTE;
                        end
                        8'b00???110:
                        begin
                            s_d.op         = OP_LOAD_IMMEDIATE_BYTE;
                            s_d.opnd_count = OPND_BYTE;
                        end
                        8'b00??0001:
                        begin
                            s_d.op         = OP_LOAD_IMMEDIATE_PAIR;
                            s_d.pair_sp    = (opc[5:4] == PAIR_HIGH);
                            s_d.opnd_count = OPND_WORD;
                        end
                        8'b000?0010:
                        begin
                            s_d.op   = OP_STORE_ACC_INDIRECT;
                            s_d.pair = {1'b0, opc[4]};
                        end
                        8'b000?1010:
                        begin
                            s_d.op   = OP_LOAD_ACC_INDIRECT;
                            s_d.pair = {1'b0, opc[4]};
                        end
                        OPC_STORE_PTR:
                        begin
                            s_d.op         = OP_STORE_POINTER_DIRECT;
                            s_d.pair       = PAIR_HL;
                            s_d.opnd_count = OPND_WORD;
                        end
                        OPC_LOAD_PTR:
                        begin
                            s_d.op         = OP_LOAD_POINTER_DIRECT;
                            s_d.pair       = PAIR_HL;
                            s_d.opnd_count = OPND_WORD;
                        end
                        OPC_SWAP_PAIRS:
                        begin
                            s_d.op   = OP_SWAP_POINTER_PAIRS;
                            s_d.pair = PAIR_HL;
                        end
                        OPC_SWAP_STACK_TOP:
                        begin
                            s_d.op   = OP_SWAP_STACK_TOP_POINTER;
                            s_d.pair = PAIR_HL;
                        end
                        8'b11??0101:
                        begin
                            s_d.op      = OP_PUSH_PAIR;
                            s_d.pair_af = (opc[5:4] == PAIR_HIGH);
                            s_d.sp_step = SP_STEP_DEC2;
                        end
                        8'b11??0001:
                        begin
                            s_d.op      = OP_POP_PAIR;
                            s_d.pair_af = (opc[5:4] == PAIR_HIGH);
                            s_d.sp_step = SP_STEP_INC2;
                        end
                        OPC_SP_INCREMENT:
                        begin
                            s_d.op      = OP_PAIR_INCREMENT;
                            s_d.pair_sp = 1'b1;
                            s_d.sp_step = SP_STEP_INC1;
                        end
                        OPC_SP_DECREMENT:
                        begin
                            s_d.op      = OP_PAIR_DECREMENT;
                            s_d.pair_sp = 1'b1;
                            s_d.sp_step = SP_STEP_DEC1;
                        end
                        OPC_BRANCH_ALWAYS:
                        begin
                            s_d.op         = OP_BRANCH_ALWAYS;
                            s_d.opnd_count = OPND_WORD;
                        end
                        8'b11???010:
                        begin
                            s_d.op         = OP_BRANCH_COND;
                            s_d.cond_used  = 1'b1;
                            s_d.opnd_count = OPND_WORD;
                        end
                        OPC_BRANCH_PTR:
                        begin
                            s_d.op   = OP_BRANCH_TO_POINTER;
                            s_d.pair = PAIR_HL;
                        end
                        OPC_SUBCALL:
                        begin
                            s_d.op         = OP_SUBCALL;
                            s_d.sp_step    = SP_STEP_DEC2;
                            s_d.opnd_count = OPND_WORD;
                        end
                        8'b11???100:
                        begin
                            s_d.op         = OP_SUBCALL_COND;
                            s_d.cond_used  = 1'b1;
                            s_d.sp_step    = SP_STEP_DEC2;
                            s_d.opnd_count = OPND_WORD;
                        end
                        default:
                            s_d.unsupported = 1'b1;
                    endcase
                    if (s_d.opnd_count == OPND_NONE)
                    begin
                        s_d.issue = 1'b1;
                        s_d.taken = 1'b1;
                    end
                    else
                    begin
                        s_d.phase = PH_LOW;
                    end
                end
            end
            PH_LOW:
            begin
                if (byte_valid_in)
                begin
                    s_d.opnd[7:0] = byte_in;
                    if (s_q.opnd_count == OPND_BYTE)
                    begin
                        s_d.phase = PH_OPCODE;
                        s_d.issue = 1'b1;
                        s_d.taken = 1'b1;
                    end
                    else
                    begin
                        s_d.phase = PH_HIGH;
                    end
                end
            end
            PH_HIGH:
            begin
                if (byte_valid_in)
                begin
                    s_d.opnd[15:8] = byte_in;
                    s_d.phase      = PH_OPCODE;
                    s_d.issue      = 1'b1;
                    s_d.taken      = s_q.cond_used ? cond_bus.holds
                                                   : 1'b1;
                    // A call that is not taken leaves the stack alone.
                    if (s_q.cond_used && !cond_bus.holds)
                    begin
                        s_d.sp_step = SP_STEP_NONE;
                    end
                end
            end
            default:
            begin
                s_d = COD_STATE_RESET;
            end
        endcase
    end

    // Unsupported opcodes issue as a one-cycle pulse so the sequencer can
    // trap them instead of stalling on a byte that never decodes.
    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            s_q <= COD_STATE_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign dec_valid_out         = s_q.issue;
    assign op_out                = s_q.op;
    assign dst_sel_out           = s_q.dst;
    assign src_sel_out           = s_q.src;
    assign dst_is_mem_out        = (s_q.dst == REG_MEM);
    assign src_is_mem_out        = (s_q.src == REG_MEM);
    assign pair_sel_out          = s_q.pair;
    assign pair_is_sp_out        = s_q.pair_sp;
    assign pair_is_acc_flags_out = s_q.pair_af;
    assign operand_out           = s_q.opnd;
    assign cond_taken_out        = s_q.taken;
    assign sp_step_out           = s_q.sp_step;
    assign unsupported_out       = s_q.unsupported;
    assign busy_out              = (s_q.phase != PH_OPCODE);

endmodule : cod_opcode_decoder

// ===== cod_prog_mem.sv
// Program memory model that feeds instruction bytes to the decoder.
`timescale 1ns/100ps
module cod_prog_mem (
    input  wire logic       mclk_in,
    input  wire logic       reset_n_in,
    input  wire logic       slow_in,
    output logic            byte_valid_out,
    output logic [7:0]      byte_out
);
    logic [7:0] fifo_q[$];

    function automatic void load(input logic [7:0] b);
        fifo_q.push_back(b);
    endfunction : load

    // Idle cycles invert the bus value on each cycle, so a decoder that
    // samples without a valid strobe sees it toggle rather than hold a steady copy.
    always @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            byte_valid_out <= 1'b0;
            byte_out       <= 8'hA5;
        end
        else if (fifo_q.size() > 0 &&
            (!slow_in || $urandom_range(1) == 1))
        begin
            byte_valid_out <= 1'b1;
            byte_out       <= fifo_q.pop_front();
        end
        else
        begin
            byte_valid_out <= 1'b0;
            byte_out       <= ~byte_out;
        end
    end
endmodule : cod_prog_mem

// ===== cod_opcode_decoder_sva.sv
// Checker of decode timing and fields at the decoder ports.
`timescale 1ns/100ps
module cod_opcode_decoder_chk
    import cod_pkg::*;
(
    input wire logic        mclk_in,
    input wire logic        reset_n_in,
    input wire logic        byte_valid_in,
    input wire logic [7:0]  byte_in,
    input wire logic        dec_valid_out,
    input wire cod_op_type  op_out,
    input wire logic [2:0]  dst_sel_out,
    input wire logic [2:0]  src_sel_out,
    input wire logic        src_is_mem_out,
    input wire logic        pair_is_sp_out,
    input wire logic        pair_is_acc_flags_out,
    input wire logic [15:0] operand_out,
    input wire logic        cond_taken_out,
    input wire logic [2:0]  sp_step_out,
    input wire logic        unsupported_out,
    input wire logic        busy_out
);
    logic [7:0] last_q;
    logic       op_take;

    default clocking dc @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);

    // A byte taken while not busy is always an opcode.
    assign op_take = byte_valid_in && !busy_out;

    always_ff @(posedge mclk_in)
        last_q <= byte_in;

    a_copy_fields: assert property (op_take && byte_in[7:6] == 2'h1 &&
        byte_in != OPC_HALT_SLOT |=> dec_valid_out &&
        dst_sel_out == last_q[5:3] && src_sel_out == last_q[2:0])
        else $error("copy fields wrong");
    a_halt_slot: assert property (op_take && byte_in == OPC_HALT_SLOT
        |=> unsupported_out && op_out == OP_NONE)
        else $error("halt slot not refused");
    a_mem_source: assert property (op_take && byte_in[7:6] == 2'h1 &&
        byte_in[2:0] == REG_MEM && byte_in != OPC_HALT_SLOT
        |=> op_out == OP_LOAD_REG_FROM_MEM && src_is_mem_out)
        else $error("memory source wrong");
    a_word_wait: assert property (op_take &&
        byte_in == OPC_BRANCH_ALWAYS |=> busy_out && !dec_valid_out)
        else $error("no wait for operand");
    a_word_order: assert property (op_take &&
        byte_in == OPC_BRANCH_ALWAYS ##1 byte_valid_in ##1 byte_valid_in
        |=> dec_valid_out && operand_out == {last_q, $past(byte_in, 2)})
        else $error("operand order wrong");
    a_push_step: assert property (op_take && byte_in ==? 8'b11??0101
        |=> sp_step_out == SP_STEP_DEC2 &&
        pair_is_acc_flags_out == (last_q[5:4] == PAIR_HIGH))
        else $error("push step wrong");
    a_pop_step: assert property (op_take && byte_in ==? 8'b11??0001
        |=> sp_step_out == SP_STEP_INC2 && op_out == OP_POP_PAIR)
        else $error("pop step wrong");
    a_sp_adjust: assert property (op_take &&
        (byte_in == OPC_SP_INCREMENT || byte_in == OPC_SP_DECREMENT)
        |=> pair_is_sp_out &&
        sp_step_out == (last_q[3] ? SP_STEP_DEC1 : SP_STEP_INC1))
        else $error("stack adjust wrong");
    a_swap_pairs: assert property (op_take &&
        byte_in == OPC_SWAP_PAIRS
        |=> dec_valid_out && op_out == OP_SWAP_POINTER_PAIRS)
        else $error("pair swap wrong");
    a_unsup_pulse: assert property (unsupported_out
        |-> dec_valid_out && op_out == OP_NONE)
        else $error("unsupported without issue");

    c_call_skip: cover property (dec_valid_out &&
        op_out == OP_SUBCALL_COND && !cond_taken_out);
    c_gap: cover property (busy_out && !byte_valid_in);
    c_unsup: cover property (unsupported_out);
endmodule : cod_opcode_decoder_chk

bind cod_opcode_decoder cod_opcode_decoder_chk u_chk (
    .mclk_in, .reset_n_in, .byte_valid_in, .byte_in, .dec_valid_out,
    .op_out, .dst_sel_out, .src_sel_out, .src_is_mem_out,
    .pair_is_sp_out, .pair_is_acc_flags_out, .operand_out,
    .cond_taken_out, .sp_step_out, .unsupported_out, .busy_out
);

// ===== test_cod_opcode_decoder.sv
// Self-checking testbench of the opcode decoder.
`timescale 1ns/100ps
module test_cod_opcode_decoder;
    import cod_pkg::*;

    typedef struct packed {
        logic [4:0]  op;
        logic [2:0]  dst;
        logic [2:0]  src;
        logic [3:0]  pair;
        logic [15:0] opnd;
        logic        taken;
        logic [2:0]  step;
        logic        unsup;
        logic [3:0]  chk;
    } cod_exp_type;

    logic mclk_in, reset_n_in, slow, byte_valid_in, dec_valid_out;
    logic [7:0] byte_in;
    logic flag_zero_in, flag_carry_in, flag_parity_in, flag_sign_in;
    cod_op_type op_out;
    logic [2:0] dst_sel_out, src_sel_out, sp_step_out;
    logic dst_is_mem_out, src_is_mem_out, pair_is_sp_out, busy_out;
    logic pair_is_acc_flags_out, cond_taken_out, unsupported_out;
    logic [1:0] pair_sel_out;
    logic [15:0] operand_out;
    int err_count, num_checks;
    cod_exp_type exp_q[$];
    cod_exp_type e;
    logic [7:0] misc [26] = '{8'h00, 8'h01, 8'h11, 8'h21, 8'h31, 8'h02, 8'h12,
        8'h0A, 8'h1A, 8'h22, 8'h2A, 8'hEB, 8'hC5, 8'hD5, 8'hE5, 8'hF5,
        8'hC1, 8'hD1, 8'hE1, 8'hF1, 8'hE3, 8'h33, 8'h3B, 8'hC3, 8'hE9,
        8'hCD};

    cod_opcode_decoder dut (.*);
    cod_prog_mem mem (.mclk_in, .reset_n_in, .slow_in(slow),
        .byte_valid_out(byte_valid_in), .byte_out(byte_in));

    always #4 mclk_in = ~mclk_in;

    task automatic check(input string what, input logic [15:0] ex, got);
        num_checks++;
        if (ex !== got)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, ex, got);
        end
    endtask : check

    task end_sim;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    // Flag index is code[2:1]; code[0] set means the flag must be true.
    function automatic logic holds(input logic [2:0] c);
        logic [3:0] fl;
        fl = {flag_sign_in, flag_parity_in, flag_carry_in, flag_zero_in};
        return fl[c[2:1]] == c[0];
    endfunction : holds

    function automatic cod_exp_type mk(input logic [7:0] o, logic [15:0] v);
        cod_exp_type x;
        logic h;
        h = holds(o[5:3]);
        x = '{op: OP_NONE, dst: o[5:3], src: o[2:0], pair: {o[5:4], 2'h0},
              opnd: v, taken: 1'b1, step: SP_STEP_NONE, default: '0};
        casez (o)
            8'h76: x.unsup = 1'b1;
            8'b01??????: {x.op, x.chk} = {(o[2:0] == REG_MEM ?
                OP_LOAD_REG_FROM_MEM : OP_COPY_REGISTER), 4'h1};
            8'h36: {x.op, x.chk} = {OP_STORE_IMMEDIATE_MEM, 4'h5};
            8'b00???110: {x.op, x.chk} = {OP_LOAD_IMMEDIATE_BYTE, 4'h5};
            8'b00??0001: {x.op, x.chk, x.pair[1]} =
                {OP_LOAD_IMMEDIATE_PAIR, 4'hA, o[5:4] == 2'h3};
            8'b000?0010: {x.op, x.chk, x.pair} =
                {OP_STORE_ACC_INDIRECT, 4'h2, 1'b0, o[4], 2'h0};
            8'b000?1010: {x.op, x.chk, x.pair} =
                {OP_LOAD_ACC_INDIRECT, 4'h2, 1'b0, o[4], 2'h0};
            8'h22: {x.op, x.chk, x.pair} = {OP_STORE_POINTER_DIRECT,
                4'hA, PAIR_HL, 2'h0};
            8'h2A: {x.op, x.chk, x.pair} = {OP_LOAD_POINTER_DIRECT,
                4'hA, PAIR_HL, 2'h0};
            8'hEB: x.op = OP_SWAP_POINTER_PAIRS;
            8'h33: {x.op, x.chk, x.pair[1], x.step} =
                {OP_PAIR_INCREMENT, 4'h2, 1'b1, SP_STEP_INC1};
            8'h3B: {x.op, x.chk, x.pair[1], x.step} =
                {OP_PAIR_DECREMENT, 4'h2, 1'b1, SP_STEP_DEC1};
            8'b11??0101: {x.op, x.chk, x.pair[0], x.step} = {OP_PUSH_PAIR,
                4'h2, o[5:4] == 2'h3, SP_STEP_DEC2};
            8'b11??0001: {x.op, x.chk, x.pair[0], x.step} = {OP_POP_PAIR,
                4'h2, o[5:4] == 2'h3, SP_STEP_INC2};
            8'hE3: x.op = OP_SWAP_STACK_TOP_POINTER;
            8'hE9: x.op = OP_BRANCH_TO_POINTER;
            8'hC3: {x.op, x.chk} = {OP_BRANCH_ALWAYS, 4'h8};
            8'hCD: {x.op, x.chk, x.step} =
                {OP_SUBCALL, 4'h8, SP_STEP_DEC2};
            8'b11???010: {x.op, x.chk, x.taken} = {OP_BRANCH_COND, 4'h8, h};
            8'b11???100: {x.op, x.chk, x.taken, x.step} = {OP_SUBCALL_COND,
                4'h8, h, (h ? SP_STEP_DEC2 : SP_STEP_NONE)};
            default: x.unsup = 1'b1;
        endcase
        if (x.chk[3:2] == 2'h1)
            x.opnd[15:8] = 8'h00;
        return x;
    endfunction : mk

    task automatic instr(input logic [7:0] o);
        cod_exp_type x;
        x = mk(o, 16'($urandom));
        exp_q.push_back(x);
        mem.load(o);
        if (x.chk[3:2] != 2'h0)
            mem.load(x.opnd[7:0]);
        if (x.chk[3])
            mem.load(x.opnd[15:8]);
    endtask : instr

    task automatic drain;
        int n;
        n = 0;
        while ((exp_q.size() != 0 || mem.fifo_q.size() != 0) && n < 3000)
        begin
            @(posedge mclk_in);
            n++;
        end
        check("pending", 16'h0, 16'(exp_q.size()));
    endtask : drain

    always @(posedge mclk_in)
    begin
        if (reset_n_in && dec_valid_out === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("spurious issue", 16'h0, 16'h1);
            else
            begin
                e = exp_q.pop_front();
                check("op", e.op, op_out);
                check("unsupported", e.unsup, unsupported_out);
                check("taken", e.taken, cond_taken_out);
                check("sp step", e.step, sp_step_out);
                check("busy", 16'h0, busy_out);
                if (e.chk[0])
                    check("regs", {e.dst, e.src, e.dst == REG_MEM,
                        e.src == REG_MEM}, {dst_sel_out, src_sel_out,
                        dst_is_mem_out, src_is_mem_out});
                if (e.chk[1])
                    check("pair", e.pair, {pair_sel_out, pair_is_sp_out,
                        pair_is_acc_flags_out});
                if (e.chk[3:2] != 2'h0)
                    check("operand", e.opnd, operand_out);
            end
        end
    end

    initial
    begin
        repeat (20000) @(posedge mclk_in);
        err_count++;
        $display("ERROR watchdog expected done seen hang");
        end_sim;
    end

    initial
    begin
        mclk_in = 1'b0;
        reset_n_in = 1'b0;
        slow = 1'b0;
        {flag_zero_in, flag_carry_in, flag_parity_in, flag_sign_in} = 4'h0;
        void'($urandom(32'h347C));
        repeat (2) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        @(posedge mclk_in);
        #1;
        check("reset state", {OP_NONE, 2'h0},
            {op_out, busy_out, dec_valid_out});
        for (int i = 8'h40; i < 8'h80; i++)
            instr(i[7:0]);
        for (int i = 0; i < 8; i++)
            instr({2'h0, i[2:0], 3'h6});
        drain();
        for (int p = 0; p < 2; p++)
        begin
            @(posedge mclk_in);
            slow <= p[0];
            foreach (misc[i])
                instr(misc[i]);
            drain();
        end
        repeat (6)
        begin
            @(posedge mclk_in);
            {flag_zero_in, flag_carry_in, flag_parity_in, flag_sign_in}
                <= 4'($urandom);
            @(posedge mclk_in);
            for (int i = 0; i < 8; i++)
            begin
                instr({2'h3, i[2:0], 3'h2});
                instr({2'h3, i[2:0], 3'h4});
            end
            drain();
        end
        repeat (4) @(posedge mclk_in);
        end_sim;
    end
endmodule : test_cod_opcode_decoder
